// file: dram_addr_mux.sv
// row and column address multiplexer for noninterleaved banks
// assumes a byte address from the processor bus, 32 bits wide
`timescale 1ns/1ps
`default_nettype none

module dram_addr_mux (
  input  wire logic [31:0]                       sys_addr,
  input  wire logic                              col_phase,
  input  wire dram_pkg::geom_e                   geometry,
  output logic      [dram_pkg::MEM_ADDR_W-1:0]   mux_addr
);

  // bit numbering: system bit n is the weight 2**n of the byte address
  logic [dram_pkg::MEM_ADDR_W-1:0] row_addr;
  logic [dram_pkg::MEM_ADDR_W-1:0] col_addr;

  always_comb begin
    row_addr = {sys_addr[22], sys_addr[23], sys_addr[21],
                sys_addr[20:12]};
    col_addr = {1'b0, sys_addr[24], sys_addr[22],
                sys_addr[11:3]};
    // narrow geometries leave the top lines of a phase unused
    case (geometry)
      dram_pkg::GEOM_10X10: begin
        row_addr[11:10] = 2'h0;
        col_addr[11:10] = 2'h0;
      end
      dram_pkg::GEOM_11X10: begin
        row_addr[11] = 1'b0;
        col_addr[11:10] = 2'h0;
      end
      dram_pkg::GEOM_12X9: begin
        col_addr[11:9] = 3'h0;
      end
      dram_pkg::GEOM_11X11: begin
        row_addr[11] = 1'b0;
      end
      default: begin
        row_addr[11:10] = 2'h0;
        col_addr[11:10] = 2'h0;
      end
    endcase
    mux_addr = col_phase ? col_addr : row_addr;
  end

endmodule

`default_nettype wire

// file: dram_edo_ctrl.sv
// edo dimm controller: address mux, strobes, data bus and cbr refresh
// assumes a simple request strobe from the processor bus side and
// a lookaside cache hit pin from the cache slot
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - one shared 12-bit multiplexed address bus
// - row phase puts bits 22,23,21,20..12 out
// - column phase: blank, 24, 22, 11..3
// - geometries 10x10, 11x10, 12x9, 11x11 supported
// - four row strobes, pairs 0/2 and 1/3
// - cbr refresh every 15.6 us automatically
// - eight column strobes and 64-bit data bus
// - output enables 0,2 and write enables 0,2
// - cache hit inhibits this controller's response
// - cache request/grant only in copyback mode
// - banks 4 to 32 MB, one linear space only at 32 MB (bank select is address bit 25)

module dram_edo_ctrl #(
  parameter int REFRESH_COUNT = dram_pkg::REFRESH_CYCLES,
  parameter int BANK_SIZE_MB  = dram_pkg::BANK_MB_MAX
) (
  input  wire logic                              clk_sys,
  input  wire logic                              rst_n,
  // processor bus side
  input  wire logic                              req_valid,
  input  wire logic                              req_write,
  input  wire logic [31:0]                       req_addr,
  input  wire logic [dram_pkg::DATA_W-1:0]       req_wdata,
  input  wire logic [dram_pkg::CAS_W-1:0]        req_byte_en,
  output logic                                   req_ready,
  output logic                                   rsp_valid,
  output logic      [dram_pkg::DATA_W-1:0]       rsp_rdata,
  input  wire dram_pkg::geom_e                   geometry,
  input  wire logic                              copyback_mode,
  // lookaside cache slot
  input  wire logic                              cache_hit_n,
  input  wire logic                              side_cache_present,
  input  wire logic                              side_cache_bus_request_n,
  output logic                                   side_cache_bus_grant_n,
  output logic                                   cache_enable,
  output logic                                   refresh_busy,
  // dimm pins
  output logic      [dram_pkg::MEM_ADDR_W-1:0]   mem_addr,
  output logic      [dram_pkg::RAS_W-1:0]        ras_n,
  output logic      [dram_pkg::CAS_W-1:0]        cas_n,
  output logic      [1:0]                        oe_n,
  output logic      [1:0]                        we_n,
  input  wire logic [dram_pkg::DATA_W-1:0]       mem_dq_in,
  output logic      [dram_pkg::DATA_W-1:0]       mem_dq_out,
  output logic                                   mem_dq_oe
);

  // ===========================================================
  // state
  localparam logic [31:0] BANK_BYTES = 32'(BANK_SIZE_MB) << 20;
  localparam logic [15:0] REFRESH_LAST = 16'(REFRESH_COUNT - 1);

  dram_pkg::state_e                 state_reg;
  logic [dram_pkg::TIMER_W-1:0]     timer_reg;
  logic [15:0]                      refresh_cnt_reg;
  logic                             refresh_pend_reg;
  logic [31:0]                      addr_reg;
  logic                             write_reg;
  logic [dram_pkg::CAS_W-1:0]       be_reg;
  logic                             bank_sel_reg;
  logic                             col_phase;
  logic [dram_pkg::MEM_ADDR_W-1:0]  mux_addr;
  logic [31:0]                      bank_offset;
  logic                             timer_done;
  logic                             take_req;

  assign timer_done = (timer_reg == '0);
  // a hit cycle is served by the cache, so it is not taken here
  assign take_req   = req_valid && cache_hit_n && !refresh_pend_reg &&
                      (state_reg == dram_pkg::ST_IDLE);
  assign req_ready  = take_req || (req_valid && !cache_hit_n);
  // one linear space: bank offset is the address modulo bank size
  assign bank_offset = req_addr & (BANK_BYTES - 32'h1);

  // ===========================================================
  // refresh interval timer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      refresh_cnt_reg <= 16'h0;
    end else if (refresh_cnt_reg == REFRESH_LAST) begin
      refresh_cnt_reg <= 16'h0;
    end else begin
      refresh_cnt_reg <= refresh_cnt_reg + 16'h1;
    end
  end

  // new tick wins over the clear that starts the cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      refresh_pend_reg <= 1'b0;
    end else if (refresh_cnt_reg == REFRESH_LAST) begin
      refresh_pend_reg <= 1'b1;
    end else if (state_reg == dram_pkg::ST_CBR_CAS) begin
      refresh_pend_reg <= 1'b0;
    end
  end

  // ===========================================================
  // access and refresh sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= dram_pkg::ST_IDLE;
      timer_reg <= '0;
    end else begin
      if (!timer_done) begin
        timer_reg <= timer_reg - dram_pkg::TIMER_W'(1);
      end
      case (state_reg)
        dram_pkg::ST_IDLE: begin
          if (refresh_pend_reg) begin
            state_reg <= dram_pkg::ST_CBR_CAS;
            timer_reg <= dram_pkg::TIMER_W'(dram_pkg::CBR_CAS_LEAD);
          end else if (take_req) begin
            state_reg <= dram_pkg::ST_ROW;
            timer_reg <= dram_pkg::TIMER_W'(dram_pkg::RAS_SETUP_CYCLES);
          end
        end
        dram_pkg::ST_ROW: if (timer_done) begin
          state_reg <= dram_pkg::ST_RAS;
          timer_reg <= dram_pkg::TIMER_W'(dram_pkg::RAS_TO_CAS_CYCLES);
        end
        dram_pkg::ST_RAS: if (timer_done) begin
          state_reg <= dram_pkg::ST_COL;
          timer_reg <= dram_pkg::TIMER_W'(dram_pkg::RAS_SETUP_CYCLES);
        end
        dram_pkg::ST_COL: if (timer_done) begin
          state_reg <= dram_pkg::ST_CAS;
          timer_reg <= dram_pkg::TIMER_W'(dram_pkg::CAS_PULSE_CYCLES);
        end
        dram_pkg::ST_CAS: if (timer_done) begin
          state_reg <= dram_pkg::ST_PRECHARGE;
          timer_reg <= dram_pkg::TIMER_W'(dram_pkg::PRECHARGE_CYCLES);
        end
        dram_pkg::ST_CBR_CAS: if (timer_done) begin
          state_reg <= dram_pkg::ST_CBR_RAS;
          timer_reg <= dram_pkg::TIMER_W'(dram_pkg::CBR_RAS_CYCLES);
        end
        dram_pkg::ST_CBR_RAS: if (timer_done) begin
          state_reg <= dram_pkg::ST_PRECHARGE;
          timer_reg <= dram_pkg::TIMER_W'(dram_pkg::PRECHARGE_CYCLES);
        end
        dram_pkg::ST_PRECHARGE: if (timer_done) begin
          state_reg <= dram_pkg::ST_IDLE;
        end
        default: state_reg <= dram_pkg::ST_IDLE;
      endcase
    end
  end

  // ===========================================================
  // request capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg     <= 32'h0;
      write_reg    <= 1'b0;
      be_reg       <= '0;
      bank_sel_reg <= 1'b0;
      mem_dq_out   <= '0;
    end else if (take_req) begin
      addr_reg     <= bank_offset;
      write_reg    <= req_write;
      be_reg       <= req_byte_en;
      bank_sel_reg <= req_addr[25];
      mem_dq_out   <= req_wdata;
    end
  end

  assign col_phase = (state_reg == dram_pkg::ST_COL) ||
                     (state_reg == dram_pkg::ST_CAS);

  dram_addr_mux u_addr_mux (
    .sys_addr  (addr_reg),
    .col_phase (col_phase),
    .geometry  (geometry),
    .mux_addr  (mux_addr)
  );

  // ===========================================================
  // pin drivers, all registered
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr  <= '0;
      ras_n     <= '1;
      cas_n     <= '1;
      oe_n      <= 2'h3;
      we_n      <= 2'h3;
      mem_dq_oe <= 1'b0;
    end else begin
      mem_addr <= mux_addr;
      case (state_reg)
        dram_pkg::ST_RAS, dram_pkg::ST_COL, dram_pkg::ST_CAS: begin
          // bank 1 is strobes 1 and 3, bank 0 is strobes 0 and 2
          ras_n <= bank_sel_reg ? 4'h5 : 4'ha;
        end
        dram_pkg::ST_CBR_RAS: ras_n <= 4'h0;
        default: ras_n <= 4'hf;
      endcase
      case (state_reg)
        dram_pkg::ST_CAS: cas_n <= ~be_reg;
        dram_pkg::ST_CBR_CAS, dram_pkg::ST_CBR_RAS: cas_n <= 8'h00;
        default: cas_n <= 8'hff;
      endcase
      // write enable low for writes, held high during cbr
      we_n <= (write_reg && col_phase) ? 2'h0 : 2'h3;
      oe_n <= (!write_reg && state_reg == dram_pkg::ST_CAS) ?
              2'h0 : 2'h3;
      mem_dq_oe <= write_reg && col_phase;
    end
  end

  // ===========================================================
  // access completion for reads and writes, read data return
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (state_reg == dram_pkg::ST_CAS) && timer_done;
      if ((state_reg == dram_pkg::ST_CAS) && timer_done && !write_reg) begin
        rsp_rdata <= mem_dq_in;
      end
    end
  end

  // ===========================================================
  // cache slot handshake
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      side_cache_bus_grant_n <= 1'b1;
      cache_enable           <= 1'b0;
    end else begin
      // grant only ever answers a request in copyback mode
      side_cache_bus_grant_n <= !(copyback_mode &&
                                  !side_cache_bus_request_n);
      cache_enable <= side_cache_present;
    end
  end

  assign refresh_busy = (state_reg == dram_pkg::ST_CBR_CAS) ||
                        (state_reg == dram_pkg::ST_CBR_RAS);

  // ===========================================================
  // checks
  sequence s_cbr_start;
    state_reg == dram_pkg::ST_IDLE && refresh_pend_reg;
  endsequence

  a_cbr_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_cbr_start |-> ##1 refresh_busy ##[1:4] (cas_n == 8'h00))
    else $error("cbr sequence wrong");
  a_refresh_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
    refresh_cnt_reg == REFRESH_LAST |=> refresh_pend_reg)
    else $error("refresh tick lost");
  a_ras_pairs: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ras_n inside {4'hf, 4'h5, 4'ha, 4'h0})
    else $error("row strobe pairing broken");
  a_ras_before_cas: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!refresh_busy && $fell(cas_n[0]) && !$past(refresh_busy)) |->
      ras_n != 4'hf)
    else $error("cas before ras in access");
  a_hit_inhibit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!cache_hit_n && state_reg == dram_pkg::ST_IDLE && !refresh_pend_reg)
      |=> state_reg == dram_pkg::ST_IDLE)
    else $error("responded on cache hit");
  a_grant_copyback: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !copyback_mode |=> side_cache_bus_grant_n)
    else $error("grant outside copyback");
  a_col_blank: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(col_phase) |-> !mem_addr[11])
    else $error("line 11 used in column");
  a_oe_we_excl: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(oe_n == 2'h0 && we_n == 2'h0))
    else $error("oe and we both low");

endmodule

`default_nettype wire

// file: dram_pkg.sv
// constants for the edo dimm address mux and refresh controller
// assumes one 200 MHz system clock and no register bus
package dram_pkg;

  // ===========================================================
  // clock and refresh timing
  localparam int CLK_PERIOD_PS      = 5000;
  localparam int REFRESH_PERIOD_NS  = 15600;
  localparam int REFRESH_CYCLES     =
    (REFRESH_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  // ===========================================================
  // edo strobe timing, in clock cycles
  localparam int RAS_SETUP_CYCLES   = 2;
  localparam int RAS_TO_CAS_CYCLES  = 3;
  localparam int CAS_PULSE_CYCLES   = 3;
  localparam int PRECHARGE_CYCLES   = 8;
  localparam int CBR_CAS_LEAD       = 2;
  localparam int CBR_RAS_CYCLES     = 8;
  localparam int TIMER_W            = 8;

  // ===========================================================
  // memory shape
  localparam int MEM_ADDR_W         = 12;
  localparam int RAS_W              = 4;
  localparam int CAS_W              = 8;
  localparam int DATA_W             = 64;
  localparam int BANK_MB_MIN        = 4;
  localparam int BANK_MB_MAX        = 32;

  // ===========================================================
  // device geometries: row bits by column bits
  typedef enum logic [2:0] {
    GEOM_10X10 = 3'h0,
    GEOM_11X10 = 3'h1,
    GEOM_12X9  = 3'h2,
    GEOM_11X11 = 3'h3
  } geom_e;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ROW       = 4'h1,
    ST_RAS       = 4'h2,
    ST_COL       = 4'h3,
    ST_CAS       = 4'h4,
    ST_PRECHARGE = 4'h5,
    ST_CBR_CAS   = 4'h6,
    ST_CBR_RAS   = 4'h7
  } state_e;

endpackage

// file: edo_dimm_address_mux_refresh_tb_top.sv
// self-checking bench for the edo dimm controller
// assumes dram_pkg, dram_edo_ctrl and edo_dram_model are compiled first
`timescale 1ns/1ps
`default_nettype none

`define chk(g, e) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); \
  end end

module edo_dimm_address_mux_refresh_tb_top;
  localparam int REF = 200;
  logic clk_sys = 0, rst_n = 0, req_valid = 0, req_write = 0;
  logic [31:0] req_addr = 32'h0;
  logic [63:0] req_wdata = 64'h0, rsp_rdata, mem_dq_in, mem_dq_out, mdl;
  logic [7:0] req_byte_en = 8'hff, cas_n, cas_q = 8'hff, exp_be;
  logic req_ready, rsp_valid, copyback_mode = 0, cache_hit_n = 1;
  logic present = 0, breq_n = 1, grant_n, cache_enable, refresh_busy;
  logic [11:0] mem_addr, exp_row, exp_col;
  logic [3:0] ras_n, ras_q = 4'hf, exp_ras;
  logic [1:0] oe_n, we_n;
  logic mem_dq_oe, exp_wr;
  dram_pkg::geom_e geometry = dram_pkg::GEOM_10X10;
  int n_mismatch = 0, num_checks = 0, cyc = 0, n_ras = 0, n_rsp = 0;
  int n_ref = 0, ref_t = 0, ref_gap = 0, g = 0;
  logic [63:0] bm [logic [24:0]];

  dram_edo_ctrl #(.REFRESH_COUNT(REF)) dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_byte_en(req_byte_en),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .geometry(geometry), .copyback_mode(copyback_mode),
    .cache_hit_n(cache_hit_n), .side_cache_present(present),
    .side_cache_bus_request_n(breq_n), .side_cache_bus_grant_n(grant_n),
    .cache_enable(cache_enable), .refresh_busy(refresh_busy),
    .mem_addr(mem_addr), .ras_n(ras_n), .cas_n(cas_n), .oe_n(oe_n),
    .we_n(we_n), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out),
    .mem_dq_oe(mem_dq_oe));
  edo_dram_model dram (.clk_sys(clk_sys), .mem_addr(mem_addr),
    .ras_n(ras_n), .cas_n(cas_n), .oe_n(oe_n), .we_n(we_n),
    .mem_dq_out(mem_dq_out), .mem_dq_in(mem_dq_in));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // reference address mux, unused top lines cleared per geometry
  function automatic logic [11:0] mux(input logic [31:0] a, input bit c,
                                      input int gi);
    int rb[4] = '{10, 11, 12, 11};
    int cb[4] = '{10, 10, 9, 11};
    logic [11:0] v;
    v = c ? {1'b0, a[24], a[22], a[11:3]} : {a[22], a[23], a[21:12]};
    return v & ((12'h1 << (c ? cb[gi] : rb[gi])) - 12'h1);
  endfunction

  // ==========================================================
  // pin monitor
  always @(posedge clk_sys) begin
    cyc++;
    if (rst_n) begin
      if (&ras_q && !(&ras_n)) begin
        if (cas_n === 8'h00) begin
          `chk(ras_n, 4'h0)
        end else begin
          n_ras++;
          `chk(ras_n, exp_ras)
          `chk(mem_addr, exp_row)
        end
      end
      if (&cas_q && cas_n === 8'h00 && &ras_n) begin
        `chk(refresh_busy, 1'b1)
        n_ref++;
        ref_gap = cyc - ref_t;
        ref_t = cyc;
      end
      // cas falling under a low ras is an access, whatever the lanes
      if (&cas_q && !(&cas_n) && !(&ras_n)) begin
        `chk(refresh_busy, 1'b0)
        `chk(mem_addr, exp_col)
        `chk(cas_n, ~exp_be)
        `chk(we_n, exp_wr ? 2'b00 : 2'b11)
        `chk(mem_dq_oe, exp_wr)
        if (!exp_wr) `chk(oe_n, 2'b00)
      end
      if (rsp_valid === 1'b1) n_rsp++;
    end
    ras_q = ras_n;
    cas_q = cas_n;
  end

  task automatic access(input logic wr, input logic [31:0] a,
                        input logic [63:0] d, input logic [7:0] be);
    int n;
    logic [24:0] k;
    n = 0;
    exp_row = mux(a, 0, g);
    exp_col = mux(a, 1, g);
    k = {a[25], exp_row, exp_col};
    mdl = bm.exists(k) ? bm[k] : 64'h0;
    exp_ras = a[25] ? 4'h5 : 4'ha;
    exp_be = be;
    exp_wr = wr;
    @(negedge clk_sys);
    req_valid = 1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_byte_en = be;
    // ready is read at the rising edge that takes the request
    @(posedge clk_sys);
    while (req_ready !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    req_valid = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    `chk(rsp_valid, 1'b1)
    if (!wr) `chk(rsp_rdata, mdl)
    for (int i = 0; i < 8; i++)
      if (be[i]) mdl[i*8 +: 8] = d[i*8 +: 8];
    if (wr) bm[k] = mdl;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end

  initial begin
    logic [31:0] a;
    int n;
    void'($urandom(25));
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1;
    `chk({ras_n, cas_n, grant_n, mem_dq_oe}, 14'h3ffe)
    $display("test reset done");
    for (g = 0; g < 4; g++) begin
      geometry = dram_pkg::geom_e'(g);
      for (int j = 0; j < 5; j++) begin
        a = (j == 0) ? 32'h03ff_fff8 : ($urandom & 32'h03ff_fff8);
        access(1, a, {$urandom, $urandom}, (j == 1) ? 8'h81 : $urandom);
        access(0, a, 64'h0, 8'hff);
      end
    end
    $display("test access done");
    // accesses may hold a refresh off; time only refreshes while idle
    n = n_ref + 3;
    repeat (1000) if (n_ref < n) @(negedge clk_sys);
    `chk(n_ref >= n, 1'b1)
    `chk(ref_gap, REF)
    $display("test refresh done");
    n = n_ras;
    @(negedge clk_sys);
    req_valid = 1;
    cache_hit_n = 0;
    req_addr = $urandom & 32'h03ff_fff8;
    #1 `chk(req_ready, 1'b1)
    @(negedge clk_sys);
    req_valid = 0;
    cache_hit_n = 1;
    repeat (20) @(negedge clk_sys);
    `chk({n_ras == n, n_rsp == 2 * 4 * 5}, 2'b11)
    $display("test hit done");
    breq_n = 0;
    present = 1;
    repeat (10) @(negedge clk_sys);
    `chk(grant_n, 1'b1)
    `chk(cache_enable, 1'b1)
    copyback_mode = 1;
    repeat (10) @(negedge clk_sys);
    `chk(grant_n, 1'b0)
    breq_n = 1;
    present = 0;
    repeat (10) @(negedge clk_sys);
    `chk({grant_n, cache_enable}, 2'b10)
    $display("test cache slot done");
    summarize();
  end
endmodule
`default_nettype wire

// file: edo_dram_model.sv
// behavioural edo dram rank behind the dimm pins
// assumes registered strobes from the controller, sampled on clk_sys
`timescale 1ns/1ps
`default_nettype none

module edo_dram_model (
  input  wire logic        clk_sys,
  input  wire logic [11:0] mem_addr,
  input  wire logic [3:0]  ras_n,
  input  wire logic [7:0]  cas_n,
  input  wire logic [1:0]  oe_n,
  input  wire logic [1:0]  we_n,
  input  wire logic [63:0] mem_dq_out,
  output logic      [63:0] mem_dq_in
);
  // ==========================================================
  // storage, kept whole across cbr refresh
  logic [63:0] mem [logic [24:0]];
  logic [11:0] row_reg = 12'h0;
  logic [11:0] col_reg = 12'h0;
  logic        bank_reg = 1'b0;
  logic [3:0]  ras_q = 4'hf;
  logic [7:0]  cas_q = 8'hff;
  logic [63:0] last_reg = 64'h0;
  logic [63:0] word;
  logic [63:0] wr_word;
  logic [24:0] key;
  logic        drive;

  assign key = {bank_reg, row_reg, col_reg};
  assign drive = (oe_n[0] == 1'b0) && (cas_n != 8'hff) && (ras_n != 4'hf);
  // released bus shows the inverse of its last sampled value, flipping every bit each clock
  assign word = mem.exists(key) ? mem[key] : 64'h0;
  assign mem_dq_in = drive ? word : ~last_reg;

  always @(posedge clk_sys) begin
    ras_q = ras_n;
    last_reg = mem_dq_in;
    if (&cas_q && cas_n != 8'hff && ras_n != 4'hf) begin
      col_reg = mem_addr;
      if (we_n == 2'b00) begin
        wr_word = mem.exists({bank_reg, row_reg, mem_addr}) ?
                  mem[{bank_reg, row_reg, mem_addr}] : 64'h0;
        for (int i = 0; i < 8; i++)
          if (!cas_n[i]) wr_word[i*8 +: 8] = mem_dq_out[i*8 +: 8];
        mem[{bank_reg, row_reg, mem_addr}] = wr_word;
      end
    end
    cas_q = cas_n;
  end

  always @(negedge ras_q[0] or negedge ras_q[1]) begin
    if (&cas_n) begin
      row_reg = mem_addr;
      bank_reg = (ras_n[1] == 1'b0);
    end
  end
endmodule
`default_nettype wire
